// File: tls_consts.vh
// constants and register map of the trigger layer sequencer
`ifndef TLS_CONSTS_VH
`define TLS_CONSTS_VH

// register byte offsets
`define TLS_REG_CTRL 8'h00
`define TLS_REG_SRC 8'h04
`define TLS_REG_ARMCNT 8'h08
`define TLS_REG_SCANCNT 8'h0c
`define TLS_REG_MEASCNT 8'h10
`define TLS_REG_SCANTMR 8'h14
`define TLS_REG_MEASTMR 8'h18
`define TLS_REG_CMD 8'h1c
`define TLS_REG_STAT 8'h20

// event sources
`define TLS_SRC_IMM 3'h0
`define TLS_SRC_EXT 3'h1
`define TLS_SRC_MAN 3'h2
`define TLS_SRC_BUS 3'h3
`define TLS_SRC_DAISY 3'h4
`define TLS_SRC_TMR 3'h5
`define TLS_SRC_HOLD 3'h6

// source register fields
`define TLS_SRC_ARM_LSB 0
`define TLS_SRC_SCAN_LSB 4
`define TLS_SRC_MEAS_LSB 8

// command register bits (write one to fire), then the scan enable bit of the control register
`define TLS_CMD_START 0
`define TLS_CMD_BUSTRG 1
`define TLS_CMD_SIGNAL 2
`define TLS_CMD_IMMED 3
`define TLS_CMD_ABORT 4
`define TLS_CTRL_SCANEN 0

// counts: zero means infinite
`define TLS_CNT_W 17
`define TLS_CNT_MAX 17'h1_869f
`define TLS_CNT_INF 17'h0_0000
`define TLS_ARMCNT_RST 17'h0_0001

// timers in milliseconds, 1 ms .. 999,999,999 ms
`define TLS_TMR_W 30
`define TLS_TMR_MIN 30'h0000_0001
`define TLS_TMR_MAX 30'h3b9a_c9ff
`define TLS_CLK_HZ 10000000
`define TLS_MS_HZ 1000
`define TLS_MS_CYC (`TLS_CLK_HZ / `TLS_MS_HZ)
// last count of a millisecond divider
`define TLS_MS_LAST 16'h270f

// axi responses
`define TLS_RESP_OKAY 2'h0
`define TLS_RESP_SLVERR 2'h2

`endif

// File: tls_sync.v
// three-stage pin synchroniser with rising-edge pulse
`timescale 1ns/1ns
`default_nettype none
module tls_sync
(
    input wire aclk,
    input wire aresetn,
    input wire pin,
    output reg rise
);
reg s1_r;
reg s2_r;
reg s3_r;
reg lvl_r;

always @(posedge aclk)
begin
    if (!aresetn)
    begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
        s3_r <= 1'b0;
        lvl_r <= 1'b0;
        rise <= 1'b0;
    end
    else
    begin
        s1_r <= pin;
        s2_r <= s1_r;
        s3_r <= s2_r;
        // change counts only once the two later stages agree
        if (s2_r == s3_r)
        begin
            lvl_r <= s3_r;
            rise <= s3_r & ~lvl_r;
        end
        else
        begin
            rise <= 1'b0;
        end
    end
end
endmodule
`default_nettype wire

// File: tls_top.v
// trigger layer sequencer with axi4-lite register slave
`timescale 1ns/1ns
`default_nettype none
`include "tls_consts.vh"
module tls_top
(
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire ext_sync_in,
    input wire daisy_sync_in,
    input wire front_panel_fire_key,
    output reg arm_indicator,
    output reg take_reading,
    output reg chan_open,
    output reg next_function,
    output reg chan_close,
    output reg trigger_ignored
);

// *****************************
// states
// *****************************
localparam ST_IDLE = 3'd0;
localparam ST_ARM = 3'd1;
localparam ST_SCAN = 3'd2;
localparam ST_MEAS = 3'd3;
localparam ST_READ = 3'd4;
localparam ST_OPEN = 3'd5;
localparam ST_NFUN = 3'd6;
localparam ST_CLOSE = 3'd7;

// *****************************
// registers
// *****************************
reg scan_en_r;
reg [2:0] arm_src_r;
reg [2:0] scan_src_r;
reg [2:0] meas_src_r;
reg [`TLS_CNT_W-1:0] arm_cnt_r;
reg [`TLS_CNT_W-1:0] scan_cnt_r;
reg [`TLS_CNT_W-1:0] meas_cnt_r;
reg [`TLS_TMR_W-1:0] scan_tmr_r;
reg [`TLS_TMR_W-1:0] meas_tmr_r;
reg [2:0] st_r;
reg [`TLS_CNT_W-1:0] arm_done_r;
reg [`TLS_CNT_W-1:0] scan_done_r;
reg [`TLS_CNT_W-1:0] meas_done_r;
reg [15:0] scan_sub_r;
reg [15:0] meas_sub_r;
reg [`TLS_TMR_W-1:0] scan_ms_r;
reg [`TLS_TMR_W-1:0] meas_ms_r;
reg scan_first_r;
reg meas_first_r;
reg [15:0] ign_cnt_r;
reg [31:0] wdat_r;
reg [7:0] wadr_r;
reg have_aw_r;
reg have_w_r;
reg cmd_start;
reg cmd_bus;
reg cmd_sig;
reg cmd_imm;
reg cmd_abort;

wire ext_ev;
wire daisy_ev;
wire key_ev;

tls_sync u_ext
(
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(ext_sync_in),
    .rise(ext_ev)
);
tls_sync u_daisy
(
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(daisy_sync_in),
    .rise(daisy_ev)
);
tls_sync u_key
(
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(front_panel_fire_key),
    .rise(key_ev)
);

// *****************************
// helpers
// *****************************
// event seen for a source; immediate is handled by each caller, timer only by the scan and measure callers
function src_event;
    input [2:0] src;
    input ext;
    input key;
    input bus;
    input daisy;
    input sig;
    begin
        case (src)
            `TLS_SRC_EXT: src_event = ext | sig;
            `TLS_SRC_MAN: src_event = key | sig;
            `TLS_SRC_BUS: src_event = bus | sig;
            `TLS_SRC_DAISY: src_event = daisy | sig;
            `TLS_SRC_HOLD: src_event = sig;
            default: src_event = sig;
        endcase
    end
endfunction

// count of zero means infinite, so last is never reached then
function cnt_last;
    input [`TLS_CNT_W-1:0] done;
    input [`TLS_CNT_W-1:0] limit;
    begin
        cnt_last = (limit != `TLS_CNT_INF) && (done + 1'b1 >= limit);
    end
endfunction

function [`TLS_CNT_W-1:0] clamp_cnt;
    input [31:0] d;
    begin
        if (d > {15'h0000, `TLS_CNT_MAX})
            clamp_cnt = `TLS_CNT_MAX;
        else
            clamp_cnt = d[`TLS_CNT_W-1:0];
    end
endfunction

function [`TLS_TMR_W-1:0] clamp_tmr;
    input [31:0] d;
    begin
        if (d < {2'b00, `TLS_TMR_MIN})
            clamp_tmr = `TLS_TMR_MIN;
        else if (d > {2'b00, `TLS_TMR_MAX})
            clamp_tmr = `TLS_TMR_MAX;
        else
            clamp_tmr = d[`TLS_TMR_W-1:0];
    end
endfunction

wire sig_any = cmd_sig | cmd_imm;
wire arm_go = (arm_src_r == `TLS_SRC_IMM) |
    src_event(arm_src_r, ext_ev, key_ev, cmd_bus, daisy_ev, sig_any);
wire scan_tmr_due = scan_first_r | (scan_ms_r == {`TLS_TMR_W{1'b0}});
wire meas_tmr_due = meas_first_r | (meas_ms_r == {`TLS_TMR_W{1'b0}});
wire scan_go = (scan_src_r == `TLS_SRC_IMM) |
    ((scan_src_r == `TLS_SRC_TMR) & (scan_tmr_due | sig_any)) |
    src_event(scan_src_r, ext_ev, key_ev, cmd_bus, daisy_ev, sig_any);
wire meas_go = (meas_src_r == `TLS_SRC_IMM) |
    ((meas_src_r == `TLS_SRC_TMR) & (meas_tmr_due | sig_any)) |
    src_event(meas_src_r, ext_ev, key_ev, cmd_bus, daisy_ev, sig_any);

// an ext or key pin event is flagged ignored only where the layer picked by cur_src (meas when idle) is immediate; daisy never is
wire [2:0] cur_src = (st_r == ST_SCAN) ? scan_src_r :
    (st_r == ST_ARM) ? arm_src_r : meas_src_r;
wire ignore_ev = (ext_ev | key_ev) & (cur_src == `TLS_SRC_IMM);

// *****************************
// axi4-lite write
// *****************************
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `TLS_RESP_OKAY;
        have_aw_r <= 1'b0;
        have_w_r <= 1'b0;
        wadr_r <= 8'h00;
        wdat_r <= 32'h0000_0000;
        scan_en_r <= 1'b0;
        arm_src_r <= `TLS_SRC_IMM;
        scan_src_r <= `TLS_SRC_IMM;
        meas_src_r <= `TLS_SRC_IMM;
        arm_cnt_r <= `TLS_ARMCNT_RST;
        scan_cnt_r <= `TLS_CNT_INF;
        meas_cnt_r <= `TLS_CNT_INF;
        scan_tmr_r <= `TLS_TMR_MIN;
        meas_tmr_r <= `TLS_TMR_MIN;
        cmd_start <= 1'b0;
        cmd_bus <= 1'b0;
        cmd_sig <= 1'b0;
        cmd_imm <= 1'b0;
        cmd_abort <= 1'b0;
    end
    else
    begin
        cmd_start <= 1'b0;
        cmd_bus <= 1'b0;
        cmd_sig <= 1'b0;
        cmd_imm <= 1'b0;
        cmd_abort <= 1'b0;
        if (s_axi_awvalid && s_axi_awready)
        begin
            wadr_r <= s_axi_awaddr;
            have_aw_r <= 1'b1;
            s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            wdat_r <= s_axi_wdata;
            have_w_r <= 1'b1;
            s_axi_wready <= 1'b0;
        end
        if (have_aw_r && have_w_r && !s_axi_bvalid)
        begin
            have_aw_r <= 1'b0;
            have_w_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `TLS_RESP_OKAY;
            // byte strobes ignored: fields are written whole
            case (wadr_r)
                `TLS_REG_CTRL: scan_en_r <= wdat_r[`TLS_CTRL_SCANEN];
                `TLS_REG_SRC:
                begin
                    arm_src_r <= wdat_r[`TLS_SRC_ARM_LSB+:3];
                    scan_src_r <= wdat_r[`TLS_SRC_SCAN_LSB+:3];
                    meas_src_r <= wdat_r[`TLS_SRC_MEAS_LSB+:3];
                end
                `TLS_REG_ARMCNT: arm_cnt_r <= clamp_cnt(wdat_r);
                `TLS_REG_SCANCNT: scan_cnt_r <= clamp_cnt(wdat_r);
                `TLS_REG_MEASCNT: meas_cnt_r <= clamp_cnt(wdat_r);
                `TLS_REG_SCANTMR: scan_tmr_r <= clamp_tmr(wdat_r);
                `TLS_REG_MEASTMR: meas_tmr_r <= clamp_tmr(wdat_r);
                `TLS_REG_CMD:
                begin
                    cmd_start <= wdat_r[`TLS_CMD_START];
                    cmd_bus <= wdat_r[`TLS_CMD_BUSTRG];
                    cmd_sig <= wdat_r[`TLS_CMD_SIGNAL];
                    cmd_imm <= wdat_r[`TLS_CMD_IMMED];
                    cmd_abort <= wdat_r[`TLS_CMD_ABORT];
                end
                `TLS_REG_STAT: s_axi_bresp <= `TLS_RESP_OKAY;
                default: s_axi_bresp <= `TLS_RESP_SLVERR;
            endcase
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
    end
end

// *****************************
// axi4-lite read
// *****************************
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `TLS_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `TLS_RESP_OKAY;
        case (s_axi_araddr)
            `TLS_REG_CTRL: s_axi_rdata <= {31'h0000_0000, scan_en_r};
            `TLS_REG_SRC: s_axi_rdata <= {21'h00_0000, meas_src_r, 1'b0,
                scan_src_r, 1'b0, arm_src_r};
            `TLS_REG_ARMCNT: s_axi_rdata <= {15'h0000, arm_cnt_r};
            `TLS_REG_SCANCNT: s_axi_rdata <= {15'h0000, scan_cnt_r};
            `TLS_REG_MEASCNT: s_axi_rdata <= {15'h0000, meas_cnt_r};
            `TLS_REG_SCANTMR: s_axi_rdata <= {2'b00, scan_tmr_r};
            `TLS_REG_MEASTMR: s_axi_rdata <= {2'b00, meas_tmr_r};
            `TLS_REG_CMD: s_axi_rdata <= 32'h0000_0000;
            `TLS_REG_STAT: s_axi_rdata <= {ign_cnt_r, 12'h000,
                arm_indicator, st_r};
            default:
            begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= `TLS_RESP_SLVERR;
            end
        endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
    end
end

// *****************************
// layer sequencer
// *****************************
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        st_r <= ST_IDLE;
        arm_indicator <= 1'b0;
        arm_done_r <= `TLS_CNT_INF;
        scan_done_r <= `TLS_CNT_INF;
        meas_done_r <= `TLS_CNT_INF;
        scan_ms_r <= {`TLS_TMR_W{1'b0}};
        meas_ms_r <= {`TLS_TMR_W{1'b0}};
        scan_sub_r <= 16'h0000;
        meas_sub_r <= 16'h0000;
        scan_first_r <= 1'b1;
        meas_first_r <= 1'b1;
        take_reading <= 1'b0;
        chan_open <= 1'b0;
        next_function <= 1'b0;
        chan_close <= 1'b0;
        trigger_ignored <= 1'b0;
        ign_cnt_r <= 16'h0000;
    end
    else
    begin
        take_reading <= 1'b0;
        chan_open <= 1'b0;
        next_function <= 1'b0;
        chan_close <= 1'b0;
        trigger_ignored <= ignore_ev;
        if (ignore_ev)
            ign_cnt_r <= ign_cnt_r + 16'h0001;
        // interval timers run from the last pass through their layer
        // own divider per timer: a shared one would cut the first ms short
        if (scan_ms_r != {`TLS_TMR_W{1'b0}})
        begin
            scan_sub_r <= scan_sub_r - 16'h0001;
            if (scan_sub_r == 16'h0000)
            begin
                scan_sub_r <= `TLS_MS_LAST;
                scan_ms_r <= scan_ms_r - 1'b1;
            end
        end
        if (meas_ms_r != {`TLS_TMR_W{1'b0}})
        begin
            meas_sub_r <= meas_sub_r - 16'h0001;
            if (meas_sub_r == 16'h0000)
            begin
                meas_sub_r <= `TLS_MS_LAST;
                meas_ms_r <= meas_ms_r - 1'b1;
            end
        end
        if (cmd_abort)
        begin
            st_r <= ST_IDLE;
            arm_indicator <= 1'b0;
        end
        else
        begin
            case (st_r)
                ST_IDLE:
                    if (cmd_start || key_ev)
                    begin
                        st_r <= ST_ARM;
                        arm_indicator <= 1'b1;
                        arm_done_r <= `TLS_CNT_INF;
                        scan_first_r <= 1'b1;
                    end
                ST_ARM:
                    if (arm_go)
                    begin
                        st_r <= ST_SCAN;
                        scan_done_r <= `TLS_CNT_INF;
                        scan_first_r <= 1'b1;
                    end
                ST_SCAN:
                    if (scan_go)
                    begin
                        st_r <= ST_MEAS;
                        scan_first_r <= 1'b0;
                        scan_ms_r <= scan_tmr_r;
                        scan_sub_r <= `TLS_MS_LAST;
                        meas_done_r <= `TLS_CNT_INF;
                        meas_first_r <= 1'b1;
                    end
                ST_MEAS:
                    if (meas_go)
                    begin
                        st_r <= ST_READ;
                        meas_first_r <= 1'b0;
                        meas_ms_r <= meas_tmr_r;
                        meas_sub_r <= `TLS_MS_LAST;
                        take_reading <= 1'b1;
                    end
                ST_READ:
                    st_r <= scan_en_r ? ST_OPEN : ST_CLOSE;
                ST_OPEN:
                begin
                    chan_open <= 1'b1;
                    st_r <= ST_NFUN;
                end
                ST_NFUN:
                begin
                    next_function <= 1'b1;
                    st_r <= ST_CLOSE;
                end
                default:
                begin
                    chan_close <= scan_en_r;
                    // end of one device action: unwind the layer counts
                    if (!cnt_last(meas_done_r, meas_cnt_r))
                    begin
                        meas_done_r <= meas_done_r + 1'b1;
                        st_r <= ST_MEAS;
                    end
                    else if (!cnt_last(scan_done_r, scan_cnt_r))
                    begin
                        scan_done_r <= scan_done_r + 1'b1;
                        st_r <= ST_SCAN;
                    end
                    else if (!cnt_last(arm_done_r, arm_cnt_r))
                    begin
                        arm_done_r <= arm_done_r + 1'b1;
                        st_r <= ST_ARM;
                    end
                    else
                    begin
                        st_r <= ST_IDLE;
                        arm_indicator <= 1'b0;
                    end
                end
            endcase
        end
    end
end
endmodule
`default_nettype wire

// File: tls_checker_asserts.sv
// port checker for the trigger layer sequencer
`timescale 1ns/1ns
`default_nettype none
module tls_checker
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic ext_sync_in,
    input wire logic front_panel_fire_key,
    input wire logic arm_indicator,
    input wire logic take_reading,
    input wire logic chan_open,
    input wire logic next_function,
    input wire logic chan_close,
    input wire logic trigger_ignored
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ********
    // cause age counters
    // ********
    // saturating, so a long idle spell never wraps into a false cause
    logic [3:0] start_age_r;
    logic [3:0] pin_age_r;
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            start_age_r <= 4'hf;
            pin_age_r <= 4'hf;
        end
        else
        begin
            start_age_r <= (s_axi_bvalid || front_panel_fire_key) ? 4'h0 :
                start_age_r + {3'h0, start_age_r != 4'hf};
            pin_age_r <= (ext_sync_in || front_panel_fire_key) ? 4'h0 :
                pin_age_r + {3'h0, pin_age_r != 4'hf};
        end
    end
    // ********
    // properties
    // ********
    property p_read_armed; take_reading |-> $past(arm_indicator); endproperty
    a_read_armed: assert property (p_read_armed)
        else $error("reading taken while idle");
    property p_arm_cause; $rose(arm_indicator) |-> start_age_r <= 4'ha;
    endproperty
    a_arm_cause: assert property (p_arm_cause)
        else $error("armed without start or key");
    property p_open_order; chan_open |-> $past(take_reading, 2); endproperty
    a_open_order: assert property (p_open_order)
        else $error("channel opened without a reading");
    property p_next_order; next_function |-> $past(chan_open); endproperty
    a_next_order: assert property (p_next_order)
        else $error("next function out of order");
    property p_close_order; chan_close |-> $past(next_function); endproperty
    a_close_order: assert property (p_close_order)
        else $error("channel closed out of order");
    property p_read_pulse; take_reading |=> !take_reading; endproperty
    a_read_pulse: assert property (p_read_pulse)
        else $error("reading pulse too long");
    property p_ign_cause; trigger_ignored |-> pin_age_r <= 4'ha; endproperty
    a_ign_cause: assert property (p_ign_cause)
        else $error("ignored flag without a pin event");
    property p_idle_quiet; $fell(arm_indicator) |=> !take_reading [*3];
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("reading after return to idle");
endmodule
bind tls_top tls_checker i_chk (.aclk, .aresetn, .s_axi_bvalid, .ext_sync_in,
    .front_panel_fire_key, .arm_indicator, .take_reading, .chan_open,
    .next_function, .chan_close, .trigger_ignored);
`default_nettype wire

// File: tls_front_panel_fire_key_src.sv
// model of the trigger pins: external sync, front panel key, daisy bus
`timescale 1ns/1ns
`default_nettype none
module tls_front_panel_fire_key_src
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [2:0] fire,
    input wire logic slow,
    output logic ext_sync_in,
    output logic front_panel_fire_key,
    output logic daisy_sync_in
);
    // ********
    // pulse stretchers
    // ********
    // a short pulse must still outlast the three-stage synchroniser
    logic [5:0] hold_r [0:2];
    always @(posedge aclk)
    begin
        for (int i = 0; i < 3; i++)
        begin
            if (!aresetn)
                hold_r[i] <= 6'h00;
            else if (fire[i])
                hold_r[i] <= slow ? 6'h28 : 6'h06;
            else if (hold_r[i] != 6'h00)
                hold_r[i] <= hold_r[i] - 6'h01;
        end
    end
    assign ext_sync_in = (hold_r[0] != 6'h00);
    assign front_panel_fire_key = (hold_r[1] != 6'h00);
    assign daisy_sync_in = (hold_r[2] != 6'h00);
endmodule
`default_nettype wire

// File: tb_trigger_layer_sequencer.sv
// self-checking bench for the trigger layer sequencer
`timescale 1ns/1ns
`default_nettype none
`include "tls_consts.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
    $display("unexpected at %0t: %h vs %h", $time, g, e); end end
module tb_trigger_layer_sequencer;
    typedef struct {logic [7:0] a; logic [31:0] w, e; logic [1:0] r;} tls_row_t;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rdat;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, slow = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, ext_sync_in, daisy_sync_in, front_panel_fire_key;
    logic arm_indicator, take_reading, chan_open, next_function, chan_close;
    logic trigger_ignored;
    logic [2:0] fire = 3'h0;
    int num_errors = 0, compares = 0, cyc = 0, n_rd = 0, n_open = 0;
    int n_ign = 0, n_nf = 0, n_cl = 0, b, c;
    logic [2:0] srcs [6] = '{`TLS_SRC_EXT, `TLS_SRC_MAN, `TLS_SRC_DAISY,
        `TLS_SRC_BUS, `TLS_SRC_HOLD, `TLS_SRC_HOLD};
    tls_row_t rows [8] = '{
        '{`TLS_REG_CTRL, 32'h0000_0001, 32'h0000_0001, `TLS_RESP_OKAY},
        '{`TLS_REG_SRC, 32'h0000_0654, 32'h0000_0654, `TLS_RESP_OKAY},
        '{`TLS_REG_ARMCNT, 32'h0002_0000, 32'h0001_869f, `TLS_RESP_OKAY},
        '{`TLS_REG_SCANCNT, 32'h0000_0000, 32'h0000_0000, `TLS_RESP_OKAY},
        '{`TLS_REG_MEASCNT, 32'h0001_86a0, 32'h0001_869f, `TLS_RESP_OKAY},
        '{`TLS_REG_SCANTMR, 32'h0000_0000, 32'h0000_0001, `TLS_RESP_OKAY},
        '{`TLS_REG_MEASTMR, 32'h3fff_ffff, 32'h3b9a_c9ff, `TLS_RESP_OKAY},
        '{8'h24, 32'h0000_0000, 32'h0000_0000, `TLS_RESP_SLVERR}};
    tls_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_sync_in,
        .daisy_sync_in, .front_panel_fire_key, .arm_indicator, .take_reading,
        .chan_open, .next_function, .chan_close, .trigger_ignored);
    tls_front_panel_fire_key_src i_src (.aclk, .aresetn, .fire, .slow, .ext_sync_in,
        .front_panel_fire_key, .daisy_sync_in);
    always #50 aclk = ~aclk;
    // ********
    // tasks
    // ********
    task automatic complete_run();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // pulse counters share the edge with the timeout
    always @(posedge aclk)
    begin
        cyc++;
        n_rd += (take_reading === 1'b1);
        n_open += (chan_open === 1'b1);
        n_ign += (trigger_ignored === 1'b1);
        n_nf += (next_function === 1'b1);
        n_cl += (chan_close === 1'b1);
        if (cyc == 40000)
        begin
            num_errors++;
            complete_run();
        end
    end
    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        rdat = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic cmd(input int n);
        wr(`TLS_REG_CMD, 32'h0000_0001 << n);
    endtask
    // 0..2 pulse a pin, 3..5 bus trigger, signal, immediate command
    task automatic event_fire(input int ev);
        if (ev < 3)
        begin
            @(posedge aclk);
            fire <= 3'h1 << ev;
            @(posedge aclk);
            fire <= 3'h0;
        end
        else
            cmd(ev - 2);
    endtask
    task automatic wait_arm(input logic lvl, input int lim);
        int k;
        k = 0;
        while (arm_indicator !== lvl && k < lim)
        begin
            @(posedge aclk);
            k++;
        end
        `CHK(arm_indicator, lvl)
    endtask
    // ********
    // main sequence
    // ********
    initial
    begin
        do_reset();
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].w);
            `CHK(rsp, rows[i].r)
            rd(rows[i].a);
            `CHK(rsp, rows[i].r)
            if (rows[i].r == `TLS_RESP_OKAY)
                `CHK(rdat, rows[i].e)
        end
        do_reset();
        rd(`TLS_REG_ARMCNT);
        `CHK(rdat, 32'h0000_0001)
        rd(`TLS_REG_MEASCNT);
        `CHK(rdat, 32'h0000_0000)
        rd(`TLS_REG_SRC);
        `CHK(rdat, 32'h0000_0000)
        c = n_ign;
        event_fire(0);
        repeat (20) @(posedge aclk);
        `CHK(n_ign - c, 1)
        rd(`TLS_REG_STAT);
        `CHK(rdat[31:16], 16'h0001)
        `CHK(rdat[3], 1'b0)
        b = n_rd;
        cmd(`TLS_CMD_START);
        wait_arm(1'b1, 20);
        c = n_ign;
        event_fire(1);
        repeat (300) @(posedge aclk);
        `CHK(n_ign - c, 1)
        `CHK(n_rd - b > 95, 1'b1)
        cmd(`TLS_CMD_ABORT);
        wait_arm(1'b0, 20);
        wr(`TLS_REG_CTRL, 32'h0000_0001);
        wr(`TLS_REG_ARMCNT, 32'h0000_0002);
        wr(`TLS_REG_SCANCNT, 32'h0000_0002);
        wr(`TLS_REG_MEASCNT, 32'h0000_0003);
        b = n_rd;
        c = n_open;
        cmd(`TLS_CMD_START);
        wait_arm(1'b1, 20);
        wait_arm(1'b0, 500);
        repeat (5) @(posedge aclk);
        `CHK(n_rd - b, 12)
        `CHK(n_open - c, 12)
        // no scan step has run before this scenario
        `CHK(n_nf, 12)
        `CHK(n_cl, 12)
        wr(`TLS_REG_ARMCNT, 32'h0000_0001);
        wr(`TLS_REG_SCANCNT, 32'h0000_0001);
        wr(`TLS_REG_MEASCNT, 32'h0000_0001);
        // each source but immediate and timer on each layer, all pins held long on the last layer
        for (int lay = 0; lay < 3; lay++)
            for (int k = 0; k < 6; k++)
            begin
                slow <= (lay == 2);
                wr(`TLS_REG_SRC, 32'(srcs[k]) << (4 * lay));
                b = n_rd;
                cmd(`TLS_CMD_START);
                repeat (40) @(posedge aclk);
                `CHK(n_rd - b, 0)
                `CHK(arm_indicator, 1'b1)
                event_fire(k);
                wait_arm(1'b0, 100);
                repeat (5) @(posedge aclk);
                `CHK(n_rd - b, 1)
            end
        // one ms interval is 10000 cycles
        for (int lay = 1; lay < 3; lay++)
        begin
            wr(`TLS_REG_SRC, 32'(`TLS_SRC_TMR) << (4 * lay));
            wr(`TLS_REG_SCANCNT, 32'h0000_0001 + (lay == 1));
            wr(`TLS_REG_MEASCNT, 32'h0000_0001 + (lay == 2));
            b = n_rd;
            cmd(`TLS_CMD_START);
            repeat (30) @(posedge aclk);
            `CHK(n_rd - b, 1)
            repeat (9900) @(posedge aclk);
            `CHK(n_rd - b, 1)
            wait_arm(1'b0, 300);
            `CHK(n_rd - b, 2)
        end
        complete_run();
    end
endmodule
`default_nettype wire
